/* bench/ssfb_tb.sv */
// Purpose: self-checking bench for the status and short flag bank
// Assumes: read data stands only in the cycle after the read strobe
// Notes: flag levels get two edges to land before each read
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ssfb_pkg::*;
   // one row of the level table: inputs beside expected reads
   typedef struct packed {
      logic [5:0] lv;
      ssfb_short_t sh;
      logic [7:0] st;
      logic [7:0] ab;
      logic [7:0] cd;
   } ssfb_row_t;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   // parity, pin b, pin a, prog done, fail-safe, converter error
   logic [5:0] lv = 6'h00;
   logic conv_done = 1'b0;
   logic [7:0] conv_result = 8'h00;
   logic [7:0] chsel;
   ssfb_short_t short_det = '0;
   logic irq;
   int n_errors = 0;
   int num_checks = 0;
   ssfb_row_t rows [9];

   // clock at 100 MHz
   always #5 core_clk = ~core_clk;

   ssfb_bank dut (
      .core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .nvm_parity_error(lv[5]), .failsafe_input_b(lv[4]),
      .failsafe_input_a(lv[3]), .nvm_program_complete(lv[2]),
      .in_failsafe_state(lv[1]), .converter_error(lv[0]),
      .conv_done(conv_done), .conv_result(conv_result),
      .converter_channel_select(chsel), .short_det(short_det), .irq(irq)
   );

   // byte and single-bit comparisons
   task automatic chk8(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8

   task automatic chk1(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data is looked at in the one cycle where it stands
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input string nm);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk8(nm, e, reg_rdata);
   endtask : rd

   // single-cycle measurement finished pulse
   task automatic pulse(input logic [7:0] r);
      @(posedge core_clk);
      conv_done <= 1'b1;
      conv_result <= r;
      @(posedge core_clk);
      conv_done <= 1'b0;
   endtask : pulse

   task automatic results;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   // hang guard: a stuck run counts as a mismatch
   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      results();
   end

   initial
   begin
      rows[0] = '{6'h20, 12'h000, 8'h80, 8'h00, 8'h00};
      rows[1] = '{6'h10, 12'h000, 8'h40, 8'h00, 8'h00};
      rows[2] = '{6'h08, 12'h000, 8'h20, 8'h00, 8'h00};
      rows[3] = '{6'h04, 12'h000, 8'h10, 8'h00, 8'h00};
      rows[4] = '{6'h02, 12'h000, 8'h08, 8'h00, 8'h00};
      rows[5] = '{6'h01, 12'h000, 8'h02, 8'h00, 8'h00};
      rows[6] = '{6'h00, 12'h8D5, 8'h00, 8'h25, 8'h43};
      rows[7] = '{6'h3F, 12'hFFF, 8'hFA, 8'h77, 8'h77};
      rows[8] = '{6'h00, 12'h000, 8'h00, 8'h00, 8'h00};
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      // reset values, marker clears after its first read
      rd(OFF_STATUS, 8'h01, "status after reset");
      rd(OFF_STATUS, 8'h00, "status second read");
      rd(OFF_RESULT, 8'h00, "result after reset");
      rd(OFF_SLS_AB, 8'h00, "shorts a b reset");
      rd(OFF_SLS_CD, 8'h00, "shorts c d reset");
      // level table, last row all faults gone
      foreach (rows[i])
      begin
         @(posedge core_clk);
         lv <= rows[i].lv;
         short_det <= rows[i].sh;
         @(posedge core_clk);
         rd(OFF_STATUS, rows[i].st, "status");
         rd(OFF_SLS_AB, rows[i].ab, "shorts a b");
         rd(OFF_SLS_CD, rows[i].cd, "shorts c d");
      end
      // rising fault levels left their events behind
      rd(OFF_ISTAT, 8'h0E, "fault events");
      // measurement flag, cleared by result read
      wr(OFF_ISTAT, 8'h0F);
      wr(OFF_IMASK, 8'h00);
      pulse(8'hA5);
      rd(OFF_STATUS, 8'h04, "meas done");
      chk1("irq masked", 1'b0, irq);
      rd(OFF_ISTAT, 8'h01, "irq status");
      rd(OFF_RESULT, 8'hA5, "result");
      rd(OFF_STATUS, 8'h00, "meas cleared by read");
      // cleared by channel select write, back to back
      pulse(8'h3C);
      wr(OFF_CHSEL, 8'h03);
      rd(OFF_STATUS, 8'h00, "meas cleared by write");
      chk8("channel", 8'h03, chsel);
      rd(OFF_CHSEL, 8'h03, "channel readback");
      rd(OFF_RESULT, 8'h3C, "result update");
      // unmask, then clear by writing one
      wr(OFF_IMASK, 8'h01);
      #1;
      chk1("irq raised", 1'b1, irq);
      rd(OFF_IMASK, 8'h01, "mask readback");
      wr(OFF_ISTAT, 8'h01);
      #1;
      chk1("irq cleared", 1'b0, irq);
      // writes to flag registers are ignored
      wr(OFF_RESULT, 8'hFF);
      wr(OFF_STATUS, 8'hFF);
      wr(OFF_SLS_AB, 8'hFF);
      rd(OFF_RESULT, 8'h3C, "result read only");
      rd(OFF_STATUS, 8'h00, "status read only");
      rd(OFF_SLS_AB, 8'h00, "shorts read only");
      rd(8'hC0, 8'h00, "unmapped");
      // completion beside a result read: set wins, old value read
      @(posedge core_clk);
      conv_done <= 1'b1;
      conv_result <= 8'h5A;
      reg_rd <= 1'b1;
      reg_addr <= OFF_RESULT;
      @(posedge core_clk);
      conv_done <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      chk8("result beside capture", 8'h3C, reg_rdata);
      rd(OFF_STATUS, 8'h04, "meas set wins");
      rd(OFF_RESULT, 8'h5A, "result after race");
      // event and write-one-to-clear in one cycle: event wins
      wr(OFF_ISTAT, 8'h01);
      #1;
      chk1("irq cleared again", 1'b0, irq);
      @(posedge core_clk);
      conv_done <= 1'b1;
      reg_wr <= 1'b1;
      reg_addr <= OFF_ISTAT;
      reg_wdata <= 8'h01;
      @(posedge core_clk);
      conv_done <= 1'b0;
      reg_wr <= 1'b0;
      #1;
      chk1("irq event beats clear", 1'b1, irq);
      // second reset in mid-run sets the marker again
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk8("channel reset", 8'h00, chsel);
      chk1("irq reset", 1'b0, irq);
      rd(OFF_STATUS, 8'h01, "status rereset");
      rd(OFF_RESULT, 8'h00, "result rereset");
      results();
   end
endmodule : testbench
`default_nettype wire

/* logic/ssfb_bank.sv */
// Purpose: status and single-led short flag bank with register port
// Assumes: all detector inputs synchronous to core_clk
// Notes: flag registers are read-only; read data one cycle after strobe
// Operation
// - parity error sets status bit 7
// - bits 6,5 follow fail-safe pins b,a
// - bit 4 shows programming completed
// - bit 3 shows fail-safe state
// - bit 2 set when measurement finishes
// - result read or channel write clears bit 2
// - bit 1 shows converter error
// - power-on reset sets bit 0
// - result register holds 8-bit measurement, reset zero
// - groups a,b shorts in bits 0-2,4-6
// - groups c,d shorts in same layout
// - short flag one when fault detected
`timescale 1ns/100ps
`default_nettype none
module ssfb_bank
   import ssfb_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [ssfb_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ssfb_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ssfb_pkg::DATA_W-1:0] reg_rdata,
   // nonvolatile memory and state inputs
   input wire logic nvm_parity_error,
   input wire logic nvm_program_complete,
   input wire logic in_failsafe_state,
   // fail-safe pins
   input wire logic failsafe_input_a,
   input wire logic failsafe_input_b,
   // converter
   input wire logic conv_done,
   input wire logic [7:0] conv_result,
   input wire logic converter_error,
   output logic [7:0] converter_channel_select,
   // short detectors
   input wire ssfb_pkg::ssfb_short_t short_det,
   // interrupt
   output logic irq
);
   import ssfb_pkg::*;

   ssfb_state_t st_q;
   ssfb_state_t st_d;
   logic rd_status;
   logic rd_result;
   logic wr_chsel;
   logic wr_istat;
   logic wr_imask;
   logic short_rise;
   logic [3:0] irq_ev;

   // address match for a one-cycle strobe
   function automatic logic hit(input logic stb,
                                input logic [7:0] addr,
                                input logic [7:0] off);
      hit = stb && (addr == off);
   endfunction : hit

   // two groups of three flags into one byte, reserved bits held low
   function automatic logic [7:0] pack_sls(input logic [2:0] lo,
                                           input logic [2:0] hi);
      pack_sls = {1'b0, hi, 1'b0, lo};
   endfunction : pack_sls

   // strobe decode
   assign rd_status = hit(reg_rd, reg_addr, OFF_STATUS);
   assign rd_result = hit(reg_rd, reg_addr, OFF_RESULT);
   assign wr_chsel = hit(reg_wr, reg_addr, OFF_CHSEL);
   assign wr_istat = hit(reg_wr, reg_addr, OFF_ISTAT);
   assign wr_imask = hit(reg_wr, reg_addr, OFF_IMASK);

   // new short on any output, compared against the held flags
   assign short_rise = |(pack_sls(short_det.group_a, short_det.group_b)
                         & ~st_q.sls_ab)
                     | |(pack_sls(short_det.group_c, short_det.group_d)
                         & ~st_q.sls_cd);

   // interrupt events: done pulse and rising edges of fault levels
   always_comb
   begin
      irq_ev = 4'h0;
      irq_ev[IRQ_MEAS] = conv_done;
      irq_ev[IRQ_CONV_ERR] = converter_error & ~st_q.status[ST_CONV_ERR];
      irq_ev[IRQ_PARITY] = nvm_parity_error & ~st_q.status[ST_PARITY];
      irq_ev[IRQ_SHORT] = short_rise;
   end

   // next state of the whole bank
   always_comb
   begin
      st_d = st_q;
      // live levels sampled once per cycle
      st_d.status[ST_PARITY] = nvm_parity_error;
      st_d.status[ST_FS_B] = failsafe_input_b;
      st_d.status[ST_FS_A] = failsafe_input_a;
      st_d.status[ST_PROG] = nvm_program_complete;
      st_d.status[ST_FAILSAFE] = in_failsafe_state;
      st_d.status[ST_CONV_ERR] = converter_error;
      // done flag: a finishing measurement beats a same-cycle clear
      if (conv_done)
      begin
         st_d.status[ST_MEAS] = 1'b1;
      end
      else if (rd_result || wr_chsel)
      begin
         st_d.status[ST_MEAS] = 1'b0;
      end
      // reset marker stays until software has seen the status once
      if (rd_status)
      begin
         st_d.status[ST_POR] = 1'b0;
      end
      // result captured only on completion so reads are stable
      if (conv_done)
      begin
         st_d.result = conv_result;
      end
      st_d.sls_ab = pack_sls(short_det.group_a, short_det.group_b);
      st_d.sls_cd = pack_sls(short_det.group_c, short_det.group_d);
      // local control registers; flag registers ignore writes
      if (wr_chsel)
      begin
         st_d.chsel = reg_wdata;
      end
      if (wr_imask)
      begin
         st_d.imask = reg_wdata[IRQ_W-1:0];
      end
      // write one to clear, events set in the same cycle win
      if (wr_istat)
      begin
         st_d.istat = st_q.istat & ~reg_wdata[IRQ_W-1:0];
      end
      st_d.istat = st_d.istat | irq_ev;
      // read data valid only in the cycle after the read strobe
      st_d.rdata = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            OFF_STATUS: st_d.rdata = st_q.status;
            OFF_RESULT: st_d.rdata = st_q.result;
            OFF_SLS_AB: st_d.rdata = st_q.sls_ab;
            OFF_SLS_CD: st_d.rdata = st_q.sls_cd;
            OFF_CHSEL: st_d.rdata = st_q.chsel;
            OFF_ISTAT: st_d.rdata = {4'h0, st_q.istat};
            OFF_IMASK: st_d.rdata = {4'h0, st_q.imask};
            default: st_d.rdata = 8'h00;
         endcase
      end
   end

   // state register; reset values give status 0x01
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q.status <= RST_STATUS;
         st_q.result <= RST_RESULT;
         st_q.sls_ab <= RST_SLS;
         st_q.sls_cd <= RST_SLS;
         st_q.chsel <= RST_CHSEL;
         st_q.istat <= RST_IRQ;
         st_q.imask <= RST_IRQ;
         st_q.rdata <= 8'h00;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // outputs straight from flops, except the interrupt gate
   assign reg_rdata = st_q.rdata;
   assign converter_channel_select = st_q.chsel;
   assign irq = |(st_q.istat & st_q.imask);

   // checks on the bank
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_result_read;
      rd_result && !conv_done;
   endsequence

   sequence s_chsel_write;
      wr_chsel && !conv_done;
   endsequence

   sequence s_status_read;
      rd_status;
   endsequence

   // done flag with no clear pending in this cycle
   sequence s_meas_pending;
      st_q.status[ST_MEAS] && !rd_result && !wr_chsel;
   endsequence

   // write-one-to-clear of the done event with no new event beside it
   sequence s_meas_w1c;
      wr_istat && reg_wdata[IRQ_MEAS] && !conv_done;
   endsequence

   parity_flag_a: assert property (
      nvm_parity_error ##1 rd_status |=> reg_rdata[ST_PARITY])
      else $error("parity error not seen in status read");

   fs_pins_a: assert property (
      rd_status ##1 1'b1 |-> reg_rdata[6:5]
         == $past({failsafe_input_b, failsafe_input_a}, 2))
      else $error("fail-safe pin levels wrong in status read");

   prog_done_a: assert property (
      rd_status |=> reg_rdata[ST_PROG] == $past(nvm_program_complete, 2))
      else $error("program complete bit wrong");

   failsafe_bit_a: assert property (
      rd_status |=> reg_rdata[ST_FAILSAFE] == $past(in_failsafe_state, 2))
      else $error("fail-safe state bit wrong");

   meas_set_a: assert property (
      conv_done ##1 rd_status |=> reg_rdata[ST_MEAS])
      else $error("measurement complete not set");

   meas_clear_a: assert property (
      (s_result_read or s_chsel_write) |=> !st_q.status[ST_MEAS])
      else $error("measurement complete not cleared");

   conv_err_a: assert property (
      $rose(converter_error) |=> st_q.status[ST_CONV_ERR] ##1 1'b1)
      else $error("converter error bit not set");

   por_clear_a: assert property (
      s_status_read ##1 (!rd_status)[*2] |-> !st_q.status[ST_POR])
      else $error("reset marker not cleared after status read");

   result_hold_a: assert property (
      conv_done ##1 rd_result |=> reg_rdata == $past(conv_result, 2))
      else $error("result register does not hold measurement");

   sls_layout_a: assert property (
      reg_rd && reg_addr == OFF_SLS_AB |=> reg_rdata
         == {1'b0, $past(short_det.group_b, 2), 1'b0,
             $past(short_det.group_a, 2)})
      else $error("groups a b short layout wrong");

   sls_cd_a: assert property (
      reg_rd && reg_addr == OFF_SLS_CD |=> reg_rdata
         == {1'b0, $past(short_det.group_d, 2), 1'b0,
             $past(short_det.group_c, 2)})
      else $error("groups c d short layout wrong");

   short_flag_a: assert property (
      short_det.group_c[0] |=> st_q.sls_cd[0])
      else $error("short flag not raised for fault");

   read_only_a: assert property (
      reg_wr && reg_addr == OFF_RESULT && !conv_done |=> $stable(st_q.result))
      else $error("result register changed by a write");

   reserved_zero_a: assert property (
      st_q.sls_ab[7] == 1'b0 && st_q.sls_ab[3] == 1'b0
         && st_q.sls_cd[7] == 1'b0 && st_q.sls_cd[3] == 1'b0)
      else $error("reserved short bits not zero");

   // sticky done flag, reset marker and held result
   meas_hold_a: assert property (
      s_meas_pending |=> st_q.status[ST_MEAS])
      else $error("measurement complete lost without a clear");

   meas_wins_a: assert property (
      conv_done |=> st_q.status[ST_MEAS])
      else $error("measurement complete lost to a same-cycle clear");

   por_hold_a: assert property (
      st_q.status[ST_POR] && !rd_status |=> st_q.status[ST_POR])
      else $error("reset marker dropped before a status read");

   result_keep_a: assert property (
      !conv_done |=> $stable(st_q.result))
      else $error("result changed without a finished measurement");

   // live fault levels must fall as well as rise
   parity_low_a: assert property (
      !nvm_parity_error |=> !st_q.status[ST_PARITY])
      else $error("parity bit set with no parity error");

   conv_err_low_a: assert property (
      !converter_error |=> !st_q.status[ST_CONV_ERR])
      else $error("converter error bit set with no error");

   // interrupt status, mask and output
   irq_event_a: assert property (
      conv_done |=> st_q.istat[IRQ_MEAS])
      else $error("done event not latched in interrupt status");

   irq_clear_a: assert property (
      s_meas_w1c |=> !st_q.istat[IRQ_MEAS])
      else $error("done event not cleared by writing one");

   irq_raise_a: assert property (
      conv_done && st_q.imask[IRQ_MEAS] && !wr_imask |=> irq)
      else $error("unmasked done event did not raise the interrupt");

   parity_event_a: assert property (
      $rose(nvm_parity_error) |=> st_q.istat[IRQ_PARITY])
      else $error("parity rise not latched in interrupt status");

   conv_err_event_a: assert property (
      $rose(converter_error) |=> st_q.istat[IRQ_CONV_ERR])
      else $error("converter error rise not latched");

   short_event_a: assert property (
      |(short_det.group_c & ~st_q.sls_cd[2:0]) |=> st_q.istat[IRQ_SHORT])
      else $error("new short not latched in interrupt status");

   imask_write_a: assert property (
      wr_imask |=> st_q.imask == $past(reg_wdata[IRQ_W-1:0]))
      else $error("interrupt mask write not taken");

   // local registers and the read path
   chsel_write_a: assert property (
      wr_chsel |=> converter_channel_select == $past(reg_wdata))
      else $error("channel select write not taken");

   rdata_upper_a: assert property (
      reg_rd && (reg_addr == OFF_ISTAT || reg_addr == OFF_IMASK)
         |=> reg_rdata[7:4] == 4'h0)
      else $error("upper bits of a four-bit register not zero");

   unmapped_read_a: assert property (
      reg_rd && (reg_addr < OFF_STATUS || reg_addr > OFF_IMASK)
         |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");

   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data present without read strobe");

endmodule : ssfb_bank
`default_nettype wire

/* pkg/ssfb_pkg.sv */
// Purpose: constants and types for the status and short flag bank
// Assumes: 8-bit register port, one clock, asynchronous reset
// Notes: offsets 0xA1..0xA4 are the flag registers, 0xB0..0xB2 local
package ssfb_pkg;
   // register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // flag register offsets
   localparam logic [7:0] OFF_STATUS = 8'hA1;
   localparam logic [7:0] OFF_RESULT = 8'hA2;
   localparam logic [7:0] OFF_SLS_AB = 8'hA3;
   localparam logic [7:0] OFF_SLS_CD = 8'hA4;
   // local control registers
   localparam logic [7:0] OFF_CHSEL = 8'hB0;
   localparam logic [7:0] OFF_ISTAT = 8'hB1;
   localparam logic [7:0] OFF_IMASK = 8'hB2;
   // status register bit positions
   localparam int ST_PARITY = 7;
   localparam int ST_FS_B = 6;
   localparam int ST_FS_A = 5;
   localparam int ST_PROG = 4;
   localparam int ST_FAILSAFE = 3;
   localparam int ST_MEAS = 2;
   localparam int ST_CONV_ERR = 1;
   localparam int ST_POR = 0;
   // interrupt status bit positions
   localparam int IRQ_MEAS = 0;
   localparam int IRQ_CONV_ERR = 1;
   localparam int IRQ_PARITY = 2;
   localparam int IRQ_SHORT = 3;
   localparam int IRQ_W = 4;
   // reset values
   localparam logic [7:0] RST_STATUS = 8'h01;
   localparam logic [7:0] RST_RESULT = 8'h00;
   localparam logic [7:0] RST_SLS = 8'h00;
   localparam logic [7:0] RST_CHSEL = 8'h00;
   localparam logic [3:0] RST_IRQ = 4'h0;
   // per-output single-led short detect levels, three outputs per group
   typedef struct packed {
      logic [2:0] group_d;
      logic [2:0] group_c;
      logic [2:0] group_b;
      logic [2:0] group_a;
   } ssfb_short_t;
   // whole state of the bank
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] result;
      logic [7:0] sls_ab;
      logic [7:0] sls_cd;
      logic [7:0] chsel;
      logic [3:0] istat;
      logic [3:0] imask;
      logic [7:0] rdata;
   } ssfb_state_t;
endpackage : ssfb_pkg
